// file: core/pmr_power_mode.sv
`timescale 1ns/1ps
`include "pmr_regs.svh"
// Summary of operation
// - selector 1 enters idle mode
// - selector 2 enters powerdown mode
// - selector above 3 forces full reset
// - selector exactly 3 never resets
// - finish running prefetch before halt or reset
// - emulation needs both pins low at release
// - latch emulation decision, hold after release
// - clock-failure detect enable follows control bit
module pmr_power_mode (
   input  wire logic       core_clk,
   input  wire logic       rst,
   input  wire logic       ext_reset_n,       // Active-low reset pin
   input  wire logic       emulation_entry_n, // Emulation entry pin
   input  wire logic       pll_enable_pin,    // PLL enable pin
   input  wire logic       pmi_valid,         // Power-mode instruction executes
   input  wire logic [7:0] pmi_key,           // Selector operand
   input  wire logic       prefetch_busy,     // Bus prefetch in progress
   input  wire logic       wake_event,        // Ends idle or powerdown
   input  wire logic       cfd_enable_bit,    // Clock-failure detect control
   output logic            pmi_done,          // Instruction retired, execution goes on
   output logic            prefetch_hold,     // Block new prefetch starts
   output logic            cpu_halt,          // CPU stopped
   output logic            idle_mode,         // Idle active
   output logic            powerdown_mode,    // Powerdown active
   output logic            chip_reset,        // Internal reset sequence
   output logic            on_circuit_emulation_mode,
   output logic            cfd_enable         // Clock-failure detect on
);
   // All sequencer state in one register
   typedef struct packed {
      pmr_pkg::pmr_state_t st;     // Sequencer state
      pmr_pkg::pmr_act_t   act;    // Pending action
      logic [7:0]          cnt;    // Reset pulse counter
      logic                done;   // Retire pulse
      logic                rpin_q; // Delayed reset pin level
      logic                emu;    // Latched emulation mode
      logic                cfd;    // Detect enable
   } pmr_state_s_t;
   pmr_state_s_t s_r;
   pmr_state_s_t s_nxt;

   // Pin levels after the three-flop filters
   logic rpin_s; // Synchronised reset pin
   logic emu_s;  // Synchronised emulation pin
   logic pll_s;  // Synchronised PLL pin

   // Pin synchronisers
   pmr_pin_sync u_rpin (.core_clk(core_clk), .rst(rst), .pin_in(ext_reset_n),
                        .pin_out(rpin_s));
   pmr_pin_sync u_emu  (.core_clk(core_clk), .rst(rst), .pin_in(emulation_entry_n),
                        .pin_out(emu_s));
   pmr_pin_sync u_pll  (.core_clk(core_clk), .rst(rst), .pin_in(pll_enable_pin),
                        .pin_out(pll_s));

   // Classify selector
   // Only used for selectors that leave run; the rest never reach it
   function automatic pmr_pkg::pmr_act_t key_act(input logic [7:0] k);
      if (k == `PMR_KEY_IDLE) begin
         key_act = pmr_pkg::PMR_ACT_IDLE;
      end else if (k == `PMR_KEY_PWRDN) begin
         key_act = pmr_pkg::PMR_ACT_PWRDN;
      end else begin
         key_act = pmr_pkg::PMR_ACT_RESET;
      end
   endfunction

   // Next-state logic
   always_comb begin
      s_nxt = s_r;
      s_nxt.done = 1'b0;
      s_nxt.rpin_q = rpin_s;
      s_nxt.cfd = cfd_enable_bit;
      // Rising edge of reset pin: sample emulation request
      if (rpin_s && !s_r.rpin_q) begin
         s_nxt.emu = !emu_s && !pll_s;
      end
      // Sequencer; selectors are only taken while running
      unique case (s_r.st)
         pmr_pkg::PMR_RUN: begin
            if (pmi_valid) begin
               if (pmi_key == `PMR_KEY_IDLE || pmi_key == `PMR_KEY_PWRDN ||
                   pmi_key > `PMR_KEY_LAST_SAFE) begin
                  s_nxt.act = key_act(pmi_key);
                  s_nxt.st = pmr_pkg::PMR_DRAIN;
               end else begin
                  s_nxt.done = 1'b1;
               end
            end
         end
         pmr_pkg::PMR_DRAIN: begin
            // Wait for the running prefetch to finish first
            if (!prefetch_busy) begin
               unique case (s_r.act)
                  pmr_pkg::PMR_ACT_IDLE: s_nxt.st = pmr_pkg::PMR_IDLE;
                  pmr_pkg::PMR_ACT_PWRDN: s_nxt.st = pmr_pkg::PMR_PWRDN;
                  default: begin
                     s_nxt.st = pmr_pkg::PMR_RESET;
                     s_nxt.cnt = `PMR_RST_CYCLES;
                  end
               endcase
            end
         end
         pmr_pkg::PMR_IDLE, pmr_pkg::PMR_PWRDN: begin
            if (wake_event) begin
               s_nxt.st = pmr_pkg::PMR_RUN;
               s_nxt.done = 1'b1;
            end
         end
         pmr_pkg::PMR_RESET: begin
            // Count down; the last count returns to run
            if (s_r.cnt == 8'h01) begin
               s_nxt.st = pmr_pkg::PMR_RUN;
            end
            s_nxt.cnt = s_r.cnt - 8'h01;
         end
      endcase
   end

   // State register
   // Edge detector resets high, like the filtered pin, so no false edge
   always_ff @(posedge core_clk) begin
      if (rst) begin
         s_r <= '{st: pmr_pkg::PMR_RUN, act: pmr_pkg::PMR_ACT_IDLE, cnt: 8'h00,
                  done: 1'b0, rpin_q: 1'b1, emu: 1'b0, cfd: 1'b0};
      end else begin
         s_r <= s_nxt;
      end
   end

   // Retire pulse and prefetch gate
   assign pmi_done = s_r.done;
   assign prefetch_hold = (s_r.st != pmr_pkg::PMR_RUN);

   // Power state decodes; the CPU is stopped in all three
   assign idle_mode = (s_r.st == pmr_pkg::PMR_IDLE);
   assign powerdown_mode = (s_r.st == pmr_pkg::PMR_PWRDN);
   assign chip_reset = (s_r.st == pmr_pkg::PMR_RESET);
   assign cpu_halt = idle_mode || powerdown_mode || chip_reset;

   // Latched mode and detect enable
   assign on_circuit_emulation_mode = s_r.emu;
   assign cfd_enable = s_r.cfd;

   // Idle selector leads to drain
   idle_key_a: assert property (@(posedge core_clk) disable iff (rst)
      (s_r.st == pmr_pkg::PMR_RUN && pmi_valid && pmi_key == 8'h01)
      |=> s_r.st == pmr_pkg::PMR_DRAIN && s_r.act == pmr_pkg::PMR_ACT_IDLE)
      else $error("idle selector not taken");
   // Powerdown selector
   pwrdn_key_a: assert property (@(posedge core_clk) disable iff (rst)
      (s_r.st == pmr_pkg::PMR_RUN && pmi_valid && pmi_key == 8'h02)
      |=> s_r.act == pmr_pkg::PMR_ACT_PWRDN)
      else $error("powerdown selector not taken");
   // Illegal selector resets
   bad_key_a: assert property (@(posedge core_clk) disable iff (rst)
      (s_r.st == pmr_pkg::PMR_RUN && pmi_valid && pmi_key > 8'h03)
      |=> s_r.act == pmr_pkg::PMR_ACT_RESET)
      else $error("illegal selector did not reset");
   // Selector three continues
   key_three_a: assert property (@(posedge core_clk) disable iff (rst)
      (s_r.st == pmr_pkg::PMR_RUN && pmi_valid && pmi_key == 8'h03)
      |=> s_r.st == pmr_pkg::PMR_RUN && pmi_done)
      else $error("selector three changed state");
   // No halt while prefetch busy
   prefetch_drain_a: assert property (@(posedge core_clk) disable iff (rst)
      (s_r.st == pmr_pkg::PMR_DRAIN && prefetch_busy) |=> !cpu_halt)
      else $error("halted during prefetch");
   // Emulation latch held between edges
   emu_hold_a: assert property (@(posedge core_clk) disable iff (rst)
      !(rpin_s && !s_r.rpin_q) |=> $stable(on_circuit_emulation_mode))
      else $error("emulation mode changed without edge");
   // Emulation needs both pins low
   emu_pins_a: assert property (@(posedge core_clk) disable iff (rst)
      (rpin_s && !s_r.rpin_q && (emu_s || pll_s)) |=> !on_circuit_emulation_mode)
      else $error("emulation entered with pin high");
   // Detect enable follows bit
   cfd_follow_a: assert property (@(posedge core_clk) disable iff (rst)
      cfd_enable_bit |=> cfd_enable)
      else $error("detect enable not following bit");
   // Selector zero retires without halt
   other_key_a: assert property (@(posedge core_clk) disable iff (rst)
      (s_r.st == pmr_pkg::PMR_RUN && pmi_valid && pmi_key == 8'h00)
      |=> pmi_done && !cpu_halt)
      else $error("selector zero not retired");

   // Drain ends in idle once the bus is quiet
   idle_entry_a: assert property (@(posedge core_clk) disable iff (rst)
      (s_r.st == pmr_pkg::PMR_DRAIN && !prefetch_busy && s_r.act == pmr_pkg::PMR_ACT_IDLE)
      |=> idle_mode && cpu_halt)
      else $error("idle not entered after drain");
   // Drain ends in powerdown once the bus is quiet
   pwrdn_entry_a: assert property (@(posedge core_clk) disable iff (rst)
      (s_r.st == pmr_pkg::PMR_DRAIN && !prefetch_busy && s_r.act == pmr_pkg::PMR_ACT_PWRDN)
      |=> powerdown_mode && cpu_halt)
      else $error("powerdown not entered after drain");
   // Halted modes held until wake
   halt_hold_a: assert property (@(posedge core_clk) disable iff (rst)
      ((idle_mode || powerdown_mode) && !wake_event) |=> $stable(s_r.st))
      else $error("halted mode left without wake");
   // Drain ends in a full reset sequence
   reset_entry_a: assert property (@(posedge core_clk) disable iff (rst)
      (s_r.st == pmr_pkg::PMR_DRAIN && !prefetch_busy && s_r.act == pmr_pkg::PMR_ACT_RESET)
      |=> chip_reset && s_r.cnt == `PMR_RST_CYCLES)
      else $error("reset sequence not started");
   // Reset held while counting
   reset_hold_a: assert property (@(posedge core_clk) disable iff (rst)
      (chip_reset && s_r.cnt != 8'h01) |=> chip_reset)
      else $error("reset sequence cut short");
   // Reset ends on last count
   reset_end_a: assert property (@(posedge core_clk) disable iff (rst)
      (chip_reset && s_r.cnt == 8'h01) |=> !chip_reset && !cpu_halt)
      else $error("reset sequence overran");
   // Halt only after a quiet bus
   halt_quiet_a: assert property (@(posedge core_clk) disable iff (rst)
      $rose(cpu_halt) |-> !$past(prefetch_busy))
      else $error("halt began with prefetch running");
   // Both pins low enter emulation
   emu_set_a: assert property (@(posedge core_clk) disable iff (rst)
      (rpin_s && !s_r.rpin_q && !emu_s && !pll_s) |=> on_circuit_emulation_mode)
      else $error("emulation not entered with pins low");
   // Detect enable off with bit clear
   cfd_clear_a: assert property (@(posedge core_clk) disable iff (rst)
      !cfd_enable_bit |=> !cfd_enable)
      else $error("detect enable not cleared");
   // Retire only while running
   done_in_run_a: assert property (@(posedge core_clk) disable iff (rst)
      pmi_done |-> !cpu_halt && !prefetch_hold)
      else $error("retire pulse outside run");
endmodule // pmr_power_mode

// file: core/pmr_regs.svh
`ifndef PMR_REGS_SVH
`define PMR_REGS_SVH
// Power-mode selector values
`define PMR_KEY_IDLE      8'h01
`define PMR_KEY_PWRDN     8'h02
`define PMR_KEY_LAST_SAFE 8'h03
// Reset pulse length in cycles
`define PMR_RST_CYCLES    8'h10
`endif

// file: core/pmr_pkg.sv
package pmr_pkg;
   // Sequencer states
   typedef enum logic [2:0] {
      PMR_RUN,
      PMR_DRAIN,
      PMR_IDLE,
      PMR_PWRDN,
      PMR_RESET
   } pmr_state_t;
   // Pending action after drain
   typedef enum logic [1:0] {
      PMR_ACT_IDLE,
      PMR_ACT_PWRDN,
      PMR_ACT_RESET
   } pmr_act_t;
endpackage

// file: core/pmr_pin_sync.sv
`timescale 1ns/1ps
// Three-flop pin synchroniser, change taken when stages two and three agree
module pmr_pin_sync (
   input  wire logic core_clk,
   input  wire logic rst,
   input  wire logic pin_in,
   output logic      pin_out
);
   typedef struct packed {
      logic [2:0] sh;   // Shift stages
      logic       q;    // Filtered level
   } pmr_sync_t;
   pmr_sync_t s_r;
   pmr_sync_t s_nxt;

   // Shift and filter
   always_comb begin
      s_nxt = s_r;
      s_nxt.sh = {s_r.sh[1:0], pin_in};
      if (s_r.sh[1] == s_r.sh[2]) begin
         s_nxt.q = s_r.sh[2];
      end
   end

   // Register; pins idle high
   always_ff @(posedge core_clk) begin
      if (rst) begin
         s_r <= '{sh: 3'h7, q: 1'b1};
      end else begin
         s_r <= s_nxt;
      end
   end

   assign pin_out = s_r.q;
endmodule // pmr_pin_sync

// file: dv/pmr_board_model.sv
`timescale 1ns/1ps
// Board side: reset pin and mode-select pins
module pmr_board_model (
   input  wire logic core_clk,          // Core clock
   output logic      ext_reset_n,       // Reset pin, active low
   output logic      emulation_entry_n, // Emulation pin, pulled up
   output logic      pll_enable_pin     // Pll pin, idles high
);
   // Pins idle high, reset released
   initial begin
      ext_reset_n = 1'b1;
      emulation_entry_n = 1'b1;
      pll_enable_pin = 1'b1;
   end
   // Reset pulse with chosen pin levels held across the rising edge
   task automatic pulse(input logic e, input logic p);
      @(negedge core_clk);
      ext_reset_n = 1'b0;
      emulation_entry_n = e;
      pll_enable_pin = p;
      repeat (4) @(negedge core_clk);
      ext_reset_n = 1'b1;
      // Pins held past the sync delay, then the pull-ups win
      repeat (6) @(negedge core_clk);
      emulation_entry_n = 1'b1;
      pll_enable_pin = 1'b1;
   endtask
endmodule // pmr_board_model

// file: dv/tb.sv
`timescale 1ns/1ps
`include "pmr_regs.svh"
module tb;
   logic       core_clk, rst, pmi_valid, prefetch_busy, wake_event, cfd_enable_bit, b;
   logic [7:0] pmi_key;                                       // Selector
   logic       ext_reset_n, emulation_entry_n, pll_enable_pin; // Board pins
   logic       pmi_done, prefetch_hold, cpu_halt, idle_mode, powerdown_mode;
   logic       chip_reset, on_circuit_emulation_mode, cfd_enable;
   logic [7:0] keys [7];                                      // Selector table
   int         bad_count = 0;
   int         num_checks = 0;
   int         n;
   pmr_power_mode DUT (.core_clk, .rst, .ext_reset_n, .emulation_entry_n, .pll_enable_pin,
      .pmi_valid, .pmi_key, .prefetch_busy, .wake_event, .cfd_enable_bit, .pmi_done,
      .prefetch_hold, .cpu_halt, .idle_mode, .powerdown_mode, .chip_reset,
      .on_circuit_emulation_mode, .cfd_enable);
   pmr_board_model brd (.core_clk, .ext_reset_n, .emulation_entry_n, .pll_enable_pin);
   // Clock, 5 ns period
   initial begin
      core_clk = 1'b0;
      forever #2.5 core_clk = ~core_clk;
   end
   // Compare and count
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // Counts, verdict, end of run
   task automatic print_verdict();
      $display("checks=%0d errors=%0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic tick(input int k);
      repeat (k) @(negedge core_clk);
   endtask
   // One instruction; busy prefetch stalls the drain
   task automatic run_key(input logic [7:0] k);
      int e;
      logic [7:0] want;
      e = (k == 8'h01) ? 1 : (k == 8'h02) ? 2 : (k > 8'h03) ? 3 : 0;
      pmi_valid = 1'b1;
      pmi_key = k;
      prefetch_busy = (e != 0);
      tick(1);
      pmi_valid = 1'b0;
      chk(8'(pmi_done), 8'(e == 0));
      if (e != 0) begin
         tick(2);
         chk(8'({cpu_halt, prefetch_hold}), 8'h01);
         prefetch_busy = 1'b0;
         tick(1);
      end
      want = 8'({e == 1, e == 2, e == 3, e != 0});
      chk(8'({idle_mode, powerdown_mode, chip_reset, cpu_halt}), want);
      if (e == 3) begin
         n = 0;
         while (chip_reset === 1'b1 && n < 40) begin
            tick(1);
            n++;
         end
         chk(n[7:0], `PMR_RST_CYCLES);
         if (n == 40) print_verdict();
      end else if (e != 0) begin
         wake_event = 1'b1;
         tick(1);
         wake_event = 1'b0;
         chk(8'({pmi_done, cpu_halt}), 8'h02);
      end
      tick(1);
   endtask
   // Watchdog
   initial begin
      repeat (5000) @(posedge core_clk);
      bad_count++;
      print_verdict();
   end
   // Main sequence
   initial begin
      {rst, pmi_valid, prefetch_busy, wake_event, cfd_enable_bit} = 5'h10;
      pmi_key = 8'h00;
      tick(2);
      rst = 1'b0;
      void'($urandom(58226));
      for (int i = 0; i < 8; i++) begin
         b = 1'($urandom);
         cfd_enable_bit = b;
         tick(1);
         chk(8'(cfd_enable), 8'(b));
      end
      keys = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'hFF, 8'h00};
      keys[6] = 8'($urandom_range(254, 4));
      foreach (keys[i]) run_key(keys[i]);
      brd.pulse(1'b0, 1'b0);
      tick(4);
      chk(8'(on_circuit_emulation_mode), 8'h01);
      brd.pulse(1'b0, 1'b1);
      tick(4);
      chk(8'(on_circuit_emulation_mode), 8'h00);
      brd.pulse(1'b0, 1'b0);
      tick(4);
      chk(8'(on_circuit_emulation_mode), 8'h01);
      brd.pulse(1'b1, 1'b0);
      tick(4);
      chk(8'(on_circuit_emulation_mode), 8'h00);
      print_verdict();
   end
endmodule // tb
